// >>> common/prescaler_regs.svh
// constants for the fractional reference prescaler
`ifndef PRESCALER_REGS_SVH
`define PRESCALER_REGS_SVH
`define DIVISOR_W        5
`define LEN_W            3
`define PATTERN_W        8
`define BOOT_DIV_RATIO   4'h9
`define BOOT_CNT_W       4
`define DIVISOR_RESET    5'h08
`define LEN_RESET        3'h0
`define PATTERN_RESET    8'h00
`endif

// >>> common/prescaler_pkg.sv
// types used by the fractional_ref_prescaler design file only
package prescaler_pkg;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } pre_state_e;
endpackage

// >>> core/boot_clk_div.sv
// fixed divide-by-nine clock enable used for the system clock after reset
`timescale 1ns/1ps
`include "prescaler_regs.svh"
module boot_clk_div
(
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   output logic      o_tick
);
   typedef struct packed
   {
      logic [`BOOT_CNT_W-1:0] cnt;
      logic                   tick;
   } boot_s;

   boot_s state_reg;
   boot_s state_next;

   always_comb
   begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (state_reg.cnt == `BOOT_DIV_RATIO - 4'h1)
      begin
         state_next.cnt  = '0;
         state_next.tick = 1'b1;
      end
      else
      begin
         state_next.cnt = state_reg.cnt + 4'h1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         state_reg <= '0;
      else if (i_ce)
         state_reg <= state_next;
   end

   assign o_tick = state_reg.tick;
endmodule

// >>> core/fractional_ref_prescaler.sv
// fractional-n reference prescaler with divide-by-nine boot clock
`timescale 1ns/1ps
`include "prescaler_regs.svh"
// Behaviour
// - the three settings are a 5-bit divisor, a 3-bit length and an 8-bit pattern held here.
// - each output period lasts divisor cycles (one cycle for divisor 0) for a pattern bit 0 and divisor plus one for 1.
// - the pattern has length field plus one steps.
// - the pattern repeats forever so the average ratio is fractional.
// - a length field of zero divides by the divisor alone and ignores the pattern.
// - after reset the system clock enable runs at the input rate divided by 9.
module fractional_ref_prescaler
(
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_ce,
   input  wire logic                  i_load,
   input  wire logic [`DIVISOR_W-1:0] i_divisor,
   input  wire logic [`LEN_W-1:0]     i_len,
   input  wire logic [`PATTERN_W-1:0] i_pattern,
   output logic                       o_ref_tick,
   output logic                       o_ref_clk,
   output logic                       o_sys_tick,
   output logic [`LEN_W-1:0]          o_step
);
   typedef struct packed
   {
      prescaler_pkg::pre_state_e st;
      logic [`DIVISOR_W-1:0]     divisor;
      logic [`LEN_W-1:0]         len;
      logic [`PATTERN_W-1:0]     pattern;
      logic [`DIVISOR_W:0]       cnt;
      logic [`LEN_W-1:0]         step;
      logic                      tick;
      logic                      clk_out;
   } pre_s;

   pre_s state_reg;
   pre_s state_next;
   logic [`DIVISOR_W:0] period;
   logic                cur_bit;

   // zero length always selects the plain divisor
   assign cur_bit = (state_reg.len == 3'h0) ? 1'b0 : state_reg.pattern[state_reg.step];
   assign period  = {1'b0, state_reg.divisor} + {5'h00, cur_bit};

   always_comb
   begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (i_load)
      begin
         // new settings restart the pattern so no step mixes old and new values
         state_next.divisor = i_divisor;
         state_next.len     = i_len;
         state_next.pattern = i_pattern;
         state_next.cnt     = '0;
         state_next.step    = i_len;
         state_next.st      = prescaler_pkg::ST_RUN;
         state_next.clk_out = 1'b0;
      end
      else
      begin
         case (state_reg.st)
            prescaler_pkg::ST_IDLE:
            begin
               state_next.cnt = '0;
            end
            prescaler_pkg::ST_RUN:
            begin
               // a zero period (divisor 0 with pattern bit 0) is clamped to one cycle per period
               if (state_reg.cnt + 6'h01 >= period)
               begin
                  state_next.cnt  = '0;
                  state_next.tick = 1'b1;
                  state_next.clk_out = 1'b0;
                  if (state_reg.step == 3'h0)
                     state_next.step = state_reg.len;
                  else
                     state_next.step = state_reg.step - 3'h1;
               end
               else
               begin
                  state_next.cnt = state_reg.cnt + 6'h01;
                  if (state_reg.cnt + 6'h01 >= (period >> 1))
                     state_next.clk_out = 1'b1;
               end
            end
            default:
            begin
               state_next.st = prescaler_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         state_reg.st      <= prescaler_pkg::ST_IDLE;
         state_reg.divisor <= `DIVISOR_RESET;
         state_reg.len     <= `LEN_RESET;
         state_reg.pattern <= `PATTERN_RESET;
         state_reg.cnt     <= '0;
         state_reg.step    <= '0;
         state_reg.tick    <= 1'b0;
         state_reg.clk_out <= 1'b0;
      end
      else if (i_ce)
         state_reg <= state_next;
   end

   boot_clk_div u_boot
   (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .o_tick    (o_sys_tick)
   );

   assign o_ref_tick = state_reg.tick;
   assign o_ref_clk  = state_reg.clk_out;
   assign o_step     = state_reg.step;

   // helpers advance only with the clock enable, so a freeze never stretches a period
   // helper: cycles since last tick
   logic [6:0] gap_reg;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || (i_ce && i_load))
         gap_reg <= '0;
      else if (i_ce)
         gap_reg <= o_ref_tick ? 7'h01 : gap_reg + 7'h01;
   end

   logic [3:0] sys_gap_reg;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         sys_gap_reg <= '0;
      else if (i_ce)
         sys_gap_reg <= o_sys_tick ? 4'h1 : sys_gap_reg + 4'h1;
   end

   chk_sys_div_nine: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && o_sys_tick && sys_gap_reg != 4'h0) |-> sys_gap_reg == 4'h9)
      else $error("boot clock period is not nine cycles");

   // the step moves on at the tick under test, so either period may match
   chk_period_len: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !i_load && o_ref_tick && gap_reg != 7'h00 && $stable(state_reg.divisor)
       && state_reg.divisor > 5'h01 && $past(i_ce))
      |-> (gap_reg == 7'(period) + 7'h00 || gap_reg == 7'($past(period))))
      else $error("reference period does not match divisor");

   chk_step_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !i_load && state_reg.tick && $past(state_reg.step) == 3'h0 && $past(i_ce)
       && !$past(i_load))
      |-> state_reg.step == state_reg.len)
      else $error("pattern did not restart at length");

   chk_step_down: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !i_load && state_reg.tick && $past(state_reg.step) != 3'h0 && $past(i_ce)
       && !$past(i_load))
      |-> state_reg.step == $past(state_reg.step) - 3'h1)
      else $error("pattern step did not count down");

   chk_len_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state_reg.len == 3'h0 |-> period == {1'b0, state_reg.divisor})
      else $error("zero length used the pattern");

   chk_load_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && i_load) |=> (state_reg.divisor == $past(i_divisor)
       && state_reg.pattern == $past(i_pattern) && state_reg.len == $past(i_len)))
      else $error("settings not captured");

   chk_run_repeat: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && state_reg.st == prescaler_pkg::ST_RUN) |=> state_reg.st == prescaler_pkg::ST_RUN)
      else $error("prescaler stopped running");

   chk_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state_reg.st == prescaler_pkg::ST_IDLE |-> !o_ref_tick)
      else $error("reference ticked before load");

   // a low clock enable must hold every field, a standing tick included
   chk_ce_freeze: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_ce |=> $stable(state_reg))
      else $error("state moved while clock enable was low");

   chk_clk_at_tick: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_ref_tick |-> !o_ref_clk)
      else $error("divided clock high at period end");

   chk_tick_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && o_ref_tick && state_reg.divisor > 5'h01) |=> !o_ref_tick)
      else $error("reference tick lasted more than one cycle");

   chk_sys_single: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && o_sys_tick) |=> !o_sys_tick)
      else $error("boot tick lasted more than one cycle");

   chk_load_restart: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && i_load) |=> (state_reg.step == $past(i_len) && state_reg.cnt == 6'h00
       && !o_ref_tick))
      else $error("load did not restart the pattern");

   chk_step_range: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      state_reg.step <= state_reg.len)
      else $error("pattern step beyond length");

   // main scenarios: fractional steps, pattern wrap, reload, freeze and boot ticks
   cov_fraction: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      o_ref_tick && state_reg.len != 3'h0);
   cov_wrap: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      o_ref_tick && state_reg.step == state_reg.len);
   cov_load: cover property (@(posedge i_ref_clk) disable iff (i_rst) i_load);
   cov_freeze: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_ce && state_reg.st == prescaler_pkg::ST_RUN);
   cov_boot: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_sys_tick);
endmodule

// >>> sim/ref_period_meter.sv
// partner model: the reference input that measures spacing between ticks
`timescale 1ns/1ps
module ref_period_meter
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_tick,
   output logic [7:0]      o_period,
   output logic            o_valid
);
   logic [7:0] cnt_reg;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         cnt_reg <= 8'h01;
         o_period <= 8'h00;
         o_valid <= 1'b0;
      end
      else
      begin
         cnt_reg <= i_tick ? 8'h01 : cnt_reg + 8'h01;
         o_period <= i_tick ? cnt_reg : o_period;
         o_valid <= i_tick;
      end
   end
endmodule

// >>> sim/tb_fractional_ref_prescaler.sv
// self-checking bench for the fractional reference prescaler
`timescale 1ns/1ps
`include "prescaler_regs.svh"
module tb_fractional_ref_prescaler;
   logic                  i_ref_clk = 1'b0;
   logic                  i_rst = 1'b1;
   logic                  i_load = 1'b0;
   logic                  i_ce = 1'b1;
   logic [`LEN_W-1:0]     step_q[$];
   logic                  sys_hold = 1'b0;
   logic                  hi_seen = 1'b0;
   logic                  tick_prev = 1'b0;
   logic [`DIVISOR_W-1:0] i_divisor = 5'h0F;
   logic [`LEN_W-1:0]     i_len = 3'h0;
   logic [`PATTERN_W-1:0] i_pattern = 8'h00;
   logic                  o_ref_tick, o_ref_clk, o_sys_tick, ref_valid, sys_valid;
   logic [`LEN_W-1:0]     o_step;
   logic [7:0]            ref_period, sys_period;
   logic [7:0]            exp_q[$];
   logic                  skip_ref = 1'b1;
   logic                  sys_seen = 1'b0;
   int                    errors = 0;
   int                    total_checks = 0;
   int                    cycles = 0;
   int                    seed = 77989;
   fractional_ref_prescaler i_fractional_ref_prescaler (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_ce(i_ce), .i_load(i_load), .i_divisor(i_divisor), .i_len(i_len),
      .i_pattern(i_pattern), .o_ref_tick(o_ref_tick), .o_ref_clk(o_ref_clk),
      .o_sys_tick(o_sys_tick), .o_step(o_step));
   ref_period_meter i_ref_meter (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_tick(o_ref_tick),
      .o_period(ref_period), .o_valid(ref_valid));
   ref_period_meter i_sys_meter (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_tick(o_sys_tick),
      .o_period(sys_period), .o_valid(sys_valid));
   initial
   begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] expected);
      total_checks++;
      if (seen !== expected)
      begin
         errors++;
         $display("FAIL %0t value %0d expected %0d", $time, seen, expected);
      end
   endtask
   task automatic test_done();
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // a new load may cut the running period short, so its first tick is not measured
   task automatic load_run(input logic [4:0] dv, input logic [2:0] ln, input logic [7:0] pt);
      int k;
      int s;
      int st;
      @(posedge i_ref_clk) #1;
      i_load = 1'b1;
      i_divisor = dv;
      i_len = ln;
      i_pattern = pt;
      @(posedge i_ref_clk) #1;
      i_load = 1'b0;
      @(posedge i_ref_clk) #1;
      exp_q.delete();
      step_q.delete();
      skip_ref = 1'b1;
      for (k = 1; k <= 2 * (ln + 1); k++)
      begin
         s = (ln - (k % (ln + 1)) + ln + 1) % (ln + 1);
         st = (s == 0) ? ln : s - 1;
         exp_q.push_back(8'(dv) + ((ln == 3'h0) ? 8'h00 : 8'(pt[s])));
         step_q.push_back(3'(st));
      end
      while (exp_q.size() > 0)
         @(posedge i_ref_clk);
   endtask
   // a frozen tick stands for many cycles, so the boot meter is ignored until it settles
   task automatic freeze_run(input int n);
      logic [`LEN_W-1:0] step_seen;
      logic              clk_seen;
      logic              tick_seen;
      int                j;
      @(posedge i_ref_clk) #1;
      sys_hold = 1'b1;
      i_ce = 1'b0;
      step_seen = o_step;
      clk_seen = o_ref_clk;
      tick_seen = o_ref_tick;
      for (j = 0; j < n; j++)
      begin
         @(posedge i_ref_clk) #1;
         check(8'(o_step), 8'(step_seen));
         check(8'(o_ref_clk), 8'(clk_seen));
         check(8'(o_ref_tick), 8'(tick_seen));
      end
      i_ce = 1'b1;
      @(posedge i_ref_clk) #1;
      sys_seen = 1'b0;
      sys_hold = 1'b0;
   endtask
   task automatic reset_run();
      int j;
      @(posedge i_ref_clk) #1;
      i_rst = 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      sys_seen = 1'b0;
      for (j = 0; j < 12; j++)
      begin
         @(posedge i_ref_clk) #1;
         check(8'(o_ref_tick), 8'h00);
         check(8'(o_step), 8'h00);
      end
   endtask
   always @(negedge i_ref_clk)
   begin
      if (ref_valid && skip_ref)
         skip_ref = 1'b0;
      else if (ref_valid && exp_q.size() > 0)
      begin
         check(ref_period, exp_q.pop_front());
         check(8'(o_step), 8'(step_q.pop_front()));
      end
      if (o_ref_tick && !tick_prev)
      begin
         check(8'(o_ref_clk), 8'h00);
         check(8'(hi_seen), 8'h01);
         hi_seen = 1'b0;
      end
      if (o_ref_clk)
         hi_seen = 1'b1;
      tick_prev = o_ref_tick;
      if (sys_valid && sys_seen && !sys_hold)
         check(sys_period, 8'h09);
      if (sys_valid && !sys_hold)
         sys_seen = 1'b1;
   end
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         test_done();
      end
   end
   initial
   begin
      int n;
      repeat (5) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      load_run(5'h0F, 3'h7, 8'hDA);
      load_run(5'h08, 3'h0, 8'hFF);
      freeze_run(3 + ($unsigned($random(seed)) % 8));
      load_run(5'h04, 3'h3, 8'($random(seed)));
      load_run(5'h03, 3'h1, 8'h02);
      reset_run();
      load_run(5'h1F, 3'h0, 8'h00);
      for (n = 0; n < 6; n++)
      begin
         load_run(5'(3 + ($unsigned($random(seed)) % 29)), 3'($random(seed)),
            8'($random(seed)));
         freeze_run(1 + ($unsigned($random(seed)) % 8));
      end
      test_done();
   end
endmodule
